//--- design/fbctl_host.sv
// Host controller that drives an asynchronous byte-wide flash by its pins
// Contract
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Wait full access time after standby
// - Host does not restart an operation a clear interrupted; the requester reissues it
`timescale 1ns/1ns
`default_nettype none
module fbctl_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire fbctl_pkg::fbctl_op_t req_op,
  input wire logic [fbctl_pkg::FBCTL_AW-1:0] req_addr,
  input wire logic [fbctl_pkg::FBCTL_DW-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [fbctl_pkg::FBCTL_DW-1:0] rsp_rdata,
  output logic rsp_fail,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n,
  output logic hw_clear_n,
  output logic [fbctl_pkg::FBCTL_AW-1:0] addr_lines,
  output logic [fbctl_pkg::FBCTL_DW-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [fbctl_pkg::FBCTL_DW-1:0] data_lines_i
);
  import fbctl_pkg::*;
  typedef enum logic [2:0] {
    FBCTL_IDLE, FBCTL_RD, FBCTL_WR, FBCTL_WREC, FBCTL_CLR, FBCTL_CREC, FBCTL_POLL2
  } fbctl_state_t;
  fbctl_state_t state_reg;
  fbctl_op_t op_reg;
  logic [FBCTL_DW-1:0] first_reg;
  fbctl_tmr_if tmr ();

  // Cycle count sized for the timer
  function automatic logic [FBCTL_CW-1:0] cyc(input int n);
    cyc = n[FBCTL_CW-1:0];
  endfunction

  fbctl_timer u_timer (
    .clock(clock),
    .rst(rst),
    .t(tmr)
  );

  // Timer load on every phase entry
  always_comb begin
    tmr.load = 1'b0;
    tmr.count = cyc(FBCTL_ACC_CYC);
    case (state_reg)
      FBCTL_IDLE: begin
        if (req_valid) begin
          tmr.load = 1'b1;
          case (req_op)
            FBCTL_OP_WRITE: tmr.count = cyc(FBCTL_WP_CYC);
            FBCTL_OP_CLEAR: tmr.count = cyc(FBCTL_RP_CYC);
            default: tmr.count = cyc(FBCTL_ACC_CYC);
          endcase
        end
      end
      FBCTL_WR: begin
        tmr.load = tmr.done;
        tmr.count = cyc(FBCTL_WH_CYC);
      end
      FBCTL_CLR: begin
        tmr.load = tmr.done;
        tmr.count = cyc(FBCTL_RH_CYC);
      end
      FBCTL_RD: begin
        // Second status read restarts the full access time
        // One extra cycle covers the gate-high gap between the two reads
        tmr.load = tmr.done && op_reg == FBCTL_OP_POLL;
        tmr.count = cyc(FBCTL_ACC_CYC) + FBCTL_CNT_ONE;
      end
      default: begin
        tmr.load = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= FBCTL_IDLE;
      op_reg <= FBCTL_OP_READ;
    end else begin
      case (state_reg)
        FBCTL_IDLE: begin
          if (req_valid) begin
            op_reg <= req_op;
            case (req_op)
              FBCTL_OP_WRITE: state_reg <= FBCTL_WR;
              FBCTL_OP_CLEAR: state_reg <= FBCTL_CLR;
              default: state_reg <= FBCTL_RD;
            endcase
          end
        end
        FBCTL_RD: begin
          if (tmr.done) begin
            state_reg <= (op_reg == FBCTL_OP_POLL) ? FBCTL_POLL2 : FBCTL_IDLE;
          end
        end
        FBCTL_POLL2: begin
          if (tmr.done) begin
            state_reg <= FBCTL_IDLE;
          end
        end
        FBCTL_WR: begin
          if (tmr.done) begin
            state_reg <= FBCTL_WREC;
          end
        end
        FBCTL_CLR: begin
          if (tmr.done) begin
            state_reg <= FBCTL_CREC;
          end
        end
        FBCTL_WREC, FBCTL_CREC: begin
          if (tmr.done) begin
            state_reg <= FBCTL_IDLE;
          end
        end
        default: state_reg <= FBCTL_IDLE;
      endcase
    end
  end

  // Pin drive; select dropped between requests so the part idles in standby
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chip_sel_n <= 1'b1;
      out_gate_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      hw_clear_n <= 1'b1;
      addr_lines <= '0;
      data_lines_o <= '0;
      data_lines_oe <= 1'b0;
    end else begin
      case (state_reg)
        FBCTL_IDLE: begin
          chip_sel_n <= 1'b1;
          out_gate_n <= 1'b1;
          wr_strobe_n <= 1'b1;
          hw_clear_n <= 1'b1;
          data_lines_oe <= 1'b0;
          if (req_valid) begin
            addr_lines <= req_addr;
            case (req_op)
              FBCTL_OP_WRITE: begin
                // Gate held high so the cycle is never a read
                chip_sel_n <= 1'b0;
                wr_strobe_n <= 1'b0;
                data_lines_o <= req_wdata;
                data_lines_oe <= 1'b1;
              end
              FBCTL_OP_CLEAR: begin
                hw_clear_n <= 1'b0;
              end
              default: begin
                chip_sel_n <= 1'b0;
                out_gate_n <= 1'b0;
              end
            endcase
          end
        end
        FBCTL_WR: begin
          if (tmr.done) begin
            // Strobe and select rise together; data held through the rise
            wr_strobe_n <= 1'b1;
            chip_sel_n <= 1'b1;
          end
        end
        FBCTL_WREC: begin
          data_lines_oe <= 1'b0;
        end
        FBCTL_RD: begin
          if (tmr.done && op_reg == FBCTL_OP_POLL) begin
            // Gate bounced so the device sees two separate status reads
            out_gate_n <= 1'b1;
          end else if (tmr.done) begin
            chip_sel_n <= 1'b1;
            out_gate_n <= 1'b1;
          end
        end
        FBCTL_POLL2: begin
          out_gate_n <= tmr.done;
          chip_sel_n <= tmr.done;
        end
        FBCTL_CLR: begin
          if (tmr.done) begin
            hw_clear_n <= 1'b1;
          end
        end
        default: begin
          hw_clear_n <= 1'b1;
        end
      endcase
    end
  end

  // Answers; poll fails only when toggle bit still moves
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_fail <= 1'b0;
      first_reg <= '0;
      req_ready <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= (state_reg == FBCTL_IDLE) && !req_valid;
      if (state_reg == FBCTL_RD && tmr.done) begin
        first_reg <= data_lines_i;
        if (op_reg != FBCTL_OP_POLL) begin
          rsp_valid <= 1'b1;
          rsp_rdata <= data_lines_i;
          rsp_fail <= 1'b0;
        end
      end else if (state_reg == FBCTL_POLL2 && tmr.done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_lines_i;
        rsp_fail <= data_lines_i[FBCTL_TOGGLE_BIT] != first_reg[FBCTL_TOGGLE_BIT];
      end else if ((state_reg == FBCTL_WREC || state_reg == FBCTL_CREC) && tmr.done) begin
        rsp_valid <= 1'b1;
        rsp_fail <= 1'b0;
      end
    end
  end
endmodule // fbctl_host
`default_nettype wire

//--- design/fbctl_pkg.sv
// Package: constants and types of the flash bus host controller
package fbctl_pkg;
  localparam int FBCTL_AW = 18;
  localparam int FBCTL_DW = 8;
  localparam int FBCTL_CLK_NS = 10;
  // Access and pulse times in ns (defaults, slowest grade)
  localparam int FBCTL_ACC_NS = 120;
  localparam int FBCTL_OE_NS = 50;
  localparam int FBCTL_WP_NS = 50;
  localparam int FBCTL_WH_NS = 30;
  localparam int FBCTL_RP_NS = 500;
  localparam int FBCTL_RH_NS = 50;
  // Least times round up to whole cycles
  localparam int FBCTL_ACC_CYC = (FBCTL_ACC_NS + FBCTL_CLK_NS - 1) / FBCTL_CLK_NS;
  localparam int FBCTL_WP_CYC = (FBCTL_WP_NS + FBCTL_CLK_NS - 1) / FBCTL_CLK_NS;
  localparam int FBCTL_WH_CYC = (FBCTL_WH_NS + FBCTL_CLK_NS - 1) / FBCTL_CLK_NS;
  localparam int FBCTL_RP_CYC = (FBCTL_RP_NS + FBCTL_CLK_NS - 1) / FBCTL_CLK_NS;
  localparam int FBCTL_RH_CYC = (FBCTL_RH_NS + FBCTL_CLK_NS - 1) / FBCTL_CLK_NS;
  localparam int FBCTL_CW = 8;
  localparam int FBCTL_POLL_BIT = 7;
  localparam int FBCTL_TOGGLE_BIT = 6;
  localparam logic [FBCTL_CW-1:0] FBCTL_CNT_ONE = 8'h01;
  typedef enum logic [1:0] {
    FBCTL_OP_READ,
    FBCTL_OP_WRITE,
    FBCTL_OP_CLEAR,
    FBCTL_OP_POLL
  } fbctl_op_t;
endpackage

//--- design/fbctl_if.sv
// Interface: timer request and done between controller and its timer
`timescale 1ns/1ns
`default_nettype none
interface fbctl_tmr_if;
  logic load;
  logic [7:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

//--- design/fbctl_timer.sv
// Down counter that times each pin phase
`timescale 1ns/1ns
`default_nettype none
module fbctl_timer (
  input wire logic clock,
  input wire logic rst,
  fbctl_tmr_if.tmr t
);
  import fbctl_pkg::*;
  logic [FBCTL_CW-1:0] cnt_reg;
  // Load then count down; done pulses on reaching one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (t.load) begin
      cnt_reg <= t.count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - FBCTL_CNT_ONE;
    end
  end
  // Done ignores load: the controller reloads on done, so gating it would loop
  assign t.done = (cnt_reg == FBCTL_CNT_ONE);
endmodule // fbctl_timer
`default_nettype wire

//--- sim/fbctl_host_assertions.sv
// Pin-timing checker for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module fbctl_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  input wire logic hw_clear_n,
  input wire logic [fbctl_pkg::FBCTL_AW-1:0] addr_lines,
  input wire logic [fbctl_pkg::FBCTL_DW-1:0] data_lines_o,
  input wire logic data_lines_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Gate stays low for the whole twelve-cycle access window
  sequence s_gate_low; (!out_gate_n) [*8] ##1 (!out_gate_n) [*4]; endsequence
  sequence s_strobe_low; (!wr_strobe_n) [*5]; endsequence
  property p_rd_pins; !out_gate_n |-> !chip_sel_n && wr_strobe_n && !data_lines_oe; endproperty
  property p_wr_pins; !wr_strobe_n |-> !chip_sel_n && out_gate_n && data_lines_oe; endproperty
  property p_clr_quiet; !hw_clear_n |-> chip_sel_n && out_gate_n && wr_strobe_n; endproperty
  property p_rd_len; $fell(out_gate_n) |-> s_gate_low ##1 out_gate_n; endproperty
  property p_wr_len; $fell(wr_strobe_n) |-> s_strobe_low ##1 wr_strobe_n; endproperty
  property p_wr_hold;
    !wr_strobe_n && !$past(wr_strobe_n) |-> $stable(data_lines_o) && $stable(addr_lines);
  endproperty
  property p_rd_addr; !out_gate_n && !$past(out_gate_n) |-> $stable(addr_lines); endproperty
  property p_clr_len; $fell(hw_clear_n) |-> (!hw_clear_n) [*8] ##43 $rose(hw_clear_n); endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read pin levels wrong");
  a_wr_pins: assert property (p_wr_pins) else $error("write pin levels wrong");
  a_clr_quiet: assert property (p_clr_quiet) else $error("pins active in clear");
  a_rd_len: assert property (p_rd_len) else $error("read window length wrong");
  a_wr_len: assert property (p_wr_len) else $error("strobe width wrong");
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  a_rd_addr: assert property (p_rd_addr) else $error("read address moved");
  a_clr_len: assert property (p_clr_len) else $error("clear pulse length wrong");
endmodule // fbctl_chk
`default_nettype wire

//--- sim/fbctl_flash_model.sv
// Behavioural flash device: array, write latches, busy status
`timescale 1ns/1ns
`default_nettype none
module fbctl_flash_model (
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic clr_n,
  input wire logic [17:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [0:255];
  logic [7:0] lat_d = 8'h00;
  logic [17:0] lat_a = 18'h0_0000;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic drive;
  logic wr_act;
  logic armed = 1'b0;
  time done_at = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  // Drive only a clean read; released lines show the inverse
  assign drive = !cs_n && !oe_n && we_n && clr_n;
  assign val = busy ? {~lat_d[7], tog, 6'h00} : mem[addr[7:0]];
  assign dout = drive ? val : ~last;
  always @(posedge oe_n) begin
    last = val;
    if (busy) tog = ~tog;
  end
  // Write window; select and strobe may move in the same step
  assign wr_act = !cs_n && !we_n && oe_n && clr_n;
  // Address on the later fall, after a short settle against same-step pin updates
  always @(posedge wr_act) begin
    armed = 1'b1;
    #1 lat_a = addr;
  end
  // Data on the earlier rise; armed stops a start-up unknown from counting
  always @(negedge wr_act) if (armed) begin
    armed = 1'b0;
    lat_d = din;
    busy = 1'b1;
    done_at = $time + 1000;
  end
  // Runs on with select high; a clear aborts it
  always #10 if (busy && $time >= done_at) begin
    mem[lat_a[7:0]] = lat_d;
    busy = 1'b0;
  end
  always @(negedge clr_n) busy = 1'b0;
endmodule // fbctl_flash_model
`default_nettype wire

//--- sim/tb_fbctl_host.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module tb_fbctl_host;
  import fbctl_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  fbctl_op_t req_op = FBCTL_OP_READ;
  logic [FBCTL_AW-1:0] req_addr = '0;
  logic [FBCTL_DW-1:0] req_wdata = '0;
  logic req_ready, rsp_valid, rsp_fail, chip_sel_n, out_gate_n, wr_strobe_n, hw_clear_n;
  logic [FBCTL_AW-1:0] addr_lines;
  logic [FBCTL_DW-1:0] rsp_rdata, data_lines_o, dev_q, bus, got;
  logic data_lines_oe, got_fail;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  // One wire level seen by both parties
  assign bus = data_lines_oe ? data_lines_o : dev_q;
  fbctl_host dut (.clock, .rst, .req_valid, .req_op, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .rsp_fail, .chip_sel_n, .out_gate_n, .wr_strobe_n, .hw_clear_n,
    .addr_lines, .data_lines_o, .data_lines_oe, .data_lines_i(bus));
  fbctl_flash_model dev (.cs_n(chip_sel_n), .oe_n(out_gate_n), .we_n(wr_strobe_n),
    .clr_n(hw_clear_n), .addr(addr_lines), .din(bus), .dout(dev_q));
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("BAD cycle_limit exp %0d got %0d", 4999, cyc);
      close_out();
    end
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, seen);
    end
  endtask
  // One request, held a single cycle, then wait for its response
  task req(input fbctl_op_t op, input logic [17:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && i < 100) begin
      @(negedge clock);
      i++;
    end
    if (i == 100) begin
      n_fail++;
      $display("BAD req_ready exp 1 got %b", req_ready);
    end
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 200) begin
      @(negedge clock);
      i++;
    end
    if (i == 200) begin
      n_fail++;
      $display("BAD rsp_valid exp 1 got %b", rsp_valid);
    end
    got = rsp_rdata;
    got_fail = rsp_fail;
  endtask
  task t_boot_reads;
    req(FBCTL_OP_READ, 18'h0_0000, 8'h00);
    chk("rd_low", 8'h5a, got);
    req(FBCTL_OP_READ, 18'h3_ffff, 8'h00);
    chk("rd_top", 8'ha5, got);
  endtask
  task t_prog_poll;
    req(FBCTL_OP_WRITE, 18'h0_0010, 8'ha5);
    req(FBCTL_OP_POLL, 18'h0_0010, 8'h00);
    chk("busy_fail", 8'h01, {7'h00, got_fail});
    chk("poll_bit", 8'h00, {7'h00, got[FBCTL_POLL_BIT]});
    repeat (120) @(negedge clock);
    req(FBCTL_OP_POLL, 18'h0_0010, 8'h00);
    chk("done_fail", 8'h00, {7'h00, got_fail});
    req(FBCTL_OP_READ, 18'h0_0010, 8'h00);
    chk("prog_rd", 8'ha5, got);
  endtask
  task t_clear_abort;
    req(FBCTL_OP_WRITE, 18'h0_0020, 8'h0f);
    req(FBCTL_OP_CLEAR, 18'h0_0000, 8'h00);
    req(FBCTL_OP_READ, 18'h0_0020, 8'h00);
    chk("abort_rd", 8'h7a, got);
    req(FBCTL_OP_WRITE, 18'h0_0020, 8'h0f);
    repeat (120) @(negedge clock);
    req(FBCTL_OP_READ, 18'h0_0020, 8'h00);
    chk("redo_rd", 8'h0f, got);
  endtask
  // Reset in mid-read: pins back to standby, ready one edge after release
  task t_mid_reset;
    @(negedge clock);
    while (req_ready !== 1'b1) begin
      @(negedge clock);
    end
    req_op = FBCTL_OP_READ;
    req_addr = 18'h0_0040;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    repeat (3) @(negedge clock);
    chk("rd_gate", 8'h00, {7'h00, out_gate_n});
    rst = 1'b1;
    @(negedge clock);
    chk("rst_pins", 8'h0f, {4'h0, chip_sel_n, out_gate_n, wr_strobe_n, hw_clear_n});
    chk("rst_oe_rdy", 8'h00, {6'h00, data_lines_oe, req_ready});
    rst = 1'b0;
    @(negedge clock);
    chk("rdy_after", 8'h01, {7'h00, req_ready});
    req(FBCTL_OP_READ, 18'h0_0040, 8'h00);
    chk("rst_rd", 8'h1a, got);
  endtask
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    t_boot_reads();
    t_prog_poll();
    t_clear_abort();
    t_mid_reset();
    close_out();
  end
endmodule // tb_fbctl_host
bind fbctl_host fbctl_chk u_chk (.clock, .rst, .chip_sel_n, .out_gate_n, .wr_strobe_n,
  .hw_clear_n, .addr_lines, .data_lines_o, .data_lines_oe);
`default_nettype wire
